//--- design/lrt_select.v
// Top of the line-standard and receive-termination select block, APB slave.
`timescale 1ns/1ps
`include "lrt_regs.vh"
module lrt_select
#(
  parameter NUM_CH = 17,
  parameter ADDR_W = 12
)
(
  // Clock, reset and enable
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Strap and override pins, high means open or driven high
  input wire mode_strap_select,
  input wire line_standard_strap,
  input wire rx_term_override_pin,
  // Per-channel resolved configuration
  output reg [NUM_CH-1:0] e1_mode,
  output reg [NUM_CH-1:0] rx_neg_in_en,
  output reg [2*NUM_CH-1:0] term_mode,
  output reg [2*NUM_CH-1:0] term_res_code
);

  // ----------------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------------

  // Returns the register region addressed.
  function [1:0] region_of;
    input [ADDR_W-1:0] a;
    begin
      region_of = a[`LRT_REGION_MSB:`LRT_REGION_LSB];
    end
  endfunction

  // Returns the channel index addressed.
  function [4:0] chan_of;
    input [ADDR_W-1:0] a;
    begin
      chan_of = a[`LRT_IDX_MSB:`LRT_IDX_LSB];
    end
  endfunction

  // Tells whether the address hits an implemented register.
  function addr_ok;
    input [ADDR_W-1:0] a;
    reg [ADDR_W-1:0] high_part;
    begin
      high_part = a >> (`LRT_REGION_MSB + 1);
      addr_ok = (high_part == {ADDR_W{1'b0}}) && (a[`LRT_BYTE_LSB_MSB:0] == 2'h0);
      if (region_of(a) == `LRT_REGION_PINS)
        addr_ok = addr_ok && (chan_of(a) == `LRT_PINS_IDX);
      else
        addr_ok = addr_ok && ({27'h000_0000, chan_of(a)} < NUM_CH);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------------
  reg [NUM_CH-1:0] chan_cfg;
  reg [`LRT_RCF_W*NUM_CH-1:0] rx_cfg;
  wire [NUM_CH-1:0] next_e1;
  wire [NUM_CH-1:0] next_sing;
  wire [2*NUM_CH-1:0] next_mode;
  wire [2*NUM_CH-1:0] next_res;
  wire write_hit;
  wire [1:0] acc_region;
  wire [4:0] acc_chan;

  // A write lands on the edge where the completed access is seen.
  assign write_hit = clk_en & psel & penable & pready & pwrite & ~pslverr;
  assign acc_region = region_of(paddr);
  assign acc_chan = chan_of(paddr);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1)
    begin : g_ch
      localparam integer CH = gi;

      // Holds the channel's line-standard bit.
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          chan_cfg[gi] <= `LRT_CHAN_RESET;
        else if (write_hit && acc_region == `LRT_REGION_CHAN && {27'h000_0000, acc_chan} == CH)
          chan_cfg[gi] <= pwdata[`LRT_CHAN_STD_BIT];
      end

      // Holds the channel's receive configuration field.
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          rx_cfg[gi*`LRT_RCF_W +: `LRT_RCF_W] <= `LRT_RCF_RESET;
        else if (write_hit && acc_region == `LRT_REGION_RXCFG && {27'h000_0000, acc_chan} == CH)
          rx_cfg[gi*`LRT_RCF_W +: `LRT_RCF_W] <= pwdata[`LRT_RCF_W-1:0];
      end

      // Decodes this channel combinationally from pins and registers.
      lrt_chan_decode u_dec
      (
        .mode_strap_select(mode_strap_select),
        .line_standard_strap(line_standard_strap),
        .rx_term_override_pin(rx_term_override_pin),
        .line_standard_bit(chan_cfg[gi]),
        .rx_config0(rx_cfg[gi*`LRT_RCF_W +: `LRT_RCF_W]),
        .e1_mode(next_e1[gi]),
        .single_ended(next_sing[gi]),
        .term_mode(next_mode[2*gi +: 2]),
        .res_code(next_res[2*gi +: 2])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Resolved outputs
  // ----------------------------------------------------------------------

  // Registers the decode every enabled cycle; the override pin reaches all
  // receivers on the next enabled edge, independent of any bus traffic.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      e1_mode <= {NUM_CH{1'b0}};
      rx_neg_in_en <= {NUM_CH{1'b1}};
      term_mode <= {2*NUM_CH{1'b0}};
      term_res_code <= {2*NUM_CH{1'b0}};
    end
    else if (clk_en)
    begin
      e1_mode <= next_e1; // RULE1 RULE2
      rx_neg_in_en <= ~next_sing; // RULE3
      term_mode <= next_mode; // RULE4 RULE12
      term_res_code <= next_res; // RULE8
    end
  end

  // ----------------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------------
  reg [31:0] next_rdata;
  integer k;

  // Picks the addressed register; status shows the resolved state.
  always @*
  begin
    next_rdata = `LRT_ZERO32;
    k = {27'h000_0000, acc_chan};
    if (k < NUM_CH)
    begin
      case (acc_region)
        `LRT_REGION_CHAN:
          next_rdata[`LRT_CHAN_STD_BIT] = chan_cfg[k];
        `LRT_REGION_RXCFG:
          next_rdata[`LRT_RCF_W-1:0] = rx_cfg[k*`LRT_RCF_W +: `LRT_RCF_W];
        `LRT_REGION_STAT:
        begin
          next_rdata[`LRT_STAT_E1_BIT] = e1_mode[k];
          next_rdata[`LRT_STAT_SING_BIT] = ~rx_neg_in_en[k];
          next_rdata[`LRT_STAT_MODE_LO +: 2] = term_mode[2*k +: 2];
          next_rdata[`LRT_STAT_RES_LO +: 2] = term_res_code[2*k +: 2];
        end
        default:
          next_rdata[`LRT_PINS_W-1:0] = {rx_term_override_pin, line_standard_strap,
            mode_strap_select};
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Access qualifiers
  // ----------------------------------------------------------------------
  wire access_start;
  wire addr_hit;

  // An access is answered once, in the cycle after its access phase begins.
  assign access_start = psel & penable & ~pready;
  // The map check is shared by the error flag and the read data path.
  assign addr_hit = addr_ok(paddr);

  // ----------------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------------

  // Answers one cycle into the access phase; unmapped addresses error.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `LRT_ZERO32;
    end
    else if (clk_en)
    begin
      if (access_start)
      begin
        pready <= 1'b1;
        pslverr <= ~addr_hit;
        prdata <= (pwrite || !addr_hit) ? `LRT_ZERO32 : next_rdata;
      end
      else
      begin
        // The answer stands for one cycle only.
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule // lrt_select

//--- pkg/lrt_regs.vh
// Constants for the line-standard and receive-termination select block.
// How it works
// RULE1 - Mode strap open: global standard from strap.
// RULE2 - Mode strap low: per-channel bit b0 selects.
// RULE3 - Bit b3 picks differential or single-ended input.
// RULE4 - Override pin low forces external matching everywhere.
// RULE5 - Override pin high: per-channel termination choice.
// RULE6 - Termination top bit zero enables internal matching.
// RULE7 - Bit b4: partial internal or fully internal.
// RULE8 - Low two bits choose internal resistor value.
// RULE9 - Termination top bit one selects external matching.
// RULE10 - Software avoids fully internal without transformer.
// RULE11 - Host uses override pin for hot-swap, switchover.
// RULE12 - Override pin acts without any register access.
// RULE13 - Single-ended input supports external matching only.
`ifndef LRT_REGS_VH
`define LRT_REGS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define LRT_REGION_CHAN 2'h0
`define LRT_REGION_RXCFG 2'h1
`define LRT_REGION_STAT 2'h2
`define LRT_REGION_PINS 2'h3
`define LRT_REGION_MSB 8
`define LRT_REGION_LSB 7
`define LRT_IDX_MSB 6
`define LRT_IDX_LSB 2
`define LRT_BYTE_LSB_MSB 1
`define LRT_PINS_IDX 5'h00
`define LRT_PINS_W 3

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define LRT_CHAN_STD_BIT 0
`define LRT_RCF_W 5
`define LRT_RCF_TERM_LO 0
`define LRT_RCF_TERM_TOP 2
`define LRT_RCF_SING_BIT 3
`define LRT_RCF_R120_BIT 4
`define LRT_RCF_RESET 5'h04
`define LRT_CHAN_RESET 1'b0
`define LRT_STAT_E1_BIT 0
`define LRT_STAT_SING_BIT 1
`define LRT_STAT_MODE_LO 2
`define LRT_STAT_RES_LO 4
`define LRT_STAT_W 6
`define LRT_ZERO32 32'h0000_0000

// ----------------------------------------------------------------------
// Decoded codes
// ----------------------------------------------------------------------
`define LRT_TERM_EXT 2'h0
`define LRT_TERM_PARTIAL 2'h1
`define LRT_TERM_FULL 2'h2
`define LRT_RES_T1_100 2'h0
`define LRT_RES_J1_110 2'h1
`define LRT_RES_E1_120 2'h2
`define LRT_RES_E1_75 2'h3

`endif

//--- design/lrt_chan_decode.v
// Per-channel decode of line standard and receive termination.
`timescale 1ns/1ps
`include "lrt_regs.vh"
module lrt_chan_decode
(
  // Strap and override pins
  input wire mode_strap_select,
  input wire line_standard_strap,
  input wire rx_term_override_pin,
  // Channel configuration
  input wire line_standard_bit,
  input wire [`LRT_RCF_W-1:0] rx_config0,
  // Decoded results
  output reg e1_mode,
  output reg single_ended,
  output reg [1:0] term_mode,
  output reg [1:0] res_code
);

  // Resolves standard, input arrangement and matching from pins and bits.
  always @*
  begin
    if (mode_strap_select)
      e1_mode = ~line_standard_strap; // RULE1
    else
      e1_mode = line_standard_bit; // RULE2
    single_ended = rx_config0[`LRT_RCF_SING_BIT]; // RULE3
    res_code = rx_config0[`LRT_RCF_TERM_LO +: 2]; // RULE8
    term_mode = `LRT_TERM_EXT;
    if (!rx_term_override_pin)
      term_mode = `LRT_TERM_EXT; // RULE4 RULE12
    else if (single_ended)
      term_mode = `LRT_TERM_EXT; // RULE13
    else if (rx_config0[`LRT_RCF_TERM_TOP])
      term_mode = `LRT_TERM_EXT; // RULE9
    else if (rx_config0[`LRT_RCF_R120_BIT])
      term_mode = `LRT_TERM_FULL; // RULE5 RULE6 RULE7
    else
      term_mode = `LRT_TERM_PARTIAL; // RULE5 RULE6 RULE7
    if (term_mode == `LRT_TERM_EXT)
      res_code = `LRT_RES_T1_100; // RULE9
  end

endmodule // lrt_chan_decode

//--- bench/lrt_pin_ctl.sv
// Pin-side model that drives the strap pins and the override pin.
`timescale 1ns/1ps
module lrt_pin_ctl
(
  // Clock
  input wire pclk,
  // Strap and override pins
  output logic mode_strap_select,
  output logic line_standard_strap,
  output logic rx_term_override_pin
);
  // Override is held low from power up so receivers stay high impedance.
  initial
  begin
    mode_strap_select = 1'b1;
    line_standard_strap = 1'b1;
    rx_term_override_pin = 1'b0;
  end
  // Applies new pin levels just after a rising edge.
  task set_pins(input logic ms, input logic ls, input logic ov);
    begin
      @(posedge pclk);
      mode_strap_select <= ms;
      line_standard_strap <= ls;
      rx_term_override_pin <= ov;
    end
  endtask
endmodule // lrt_pin_ctl

//--- bench/lrt_select_chk.sv
// Assertion checker for the select block ports.
`timescale 1ns/1ps
module lrt_select_chk #(parameter NUM_CH = 17, parameter ADDR_W = 12)
(
  // Clock, reset and APB
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Pins and resolved outputs
  input wire mode_strap_select,
  input wire line_standard_strap,
  input wire rx_term_override_pin,
  input wire [NUM_CH-1:0] e1_mode,
  input wire [NUM_CH-1:0] rx_neg_in_en,
  input wire [2*NUM_CH-1:0] term_mode,
  input wire [2*NUM_CH-1:0] term_res_code
);
  // All checks share the one clock and reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [NUM_CH-1:0] ext_res_bad;
  logic [NUM_CH-1:0] sing_term_bad;
  // Flags channels whose resolved state breaks the external or single-ended rules.
  always_comb
  begin
    for (int n = 0; n < NUM_CH; n++)
    begin
      ext_res_bad[n] = term_mode[2*n +: 2] == 2'h0 && term_res_code[2*n +: 2] != 2'h0;
      sing_term_bad[n] = !rx_neg_in_en[n] && term_mode[2*n +: 2] != 2'h0;
    end
  end
  a_global_t1: assert property (clk_en && mode_strap_select && line_standard_strap
    |=> e1_mode == '0) else $error("global T1 not applied");
  a_global_e1: assert property (clk_en && mode_strap_select && !line_standard_strap
    |=> &e1_mode) else $error("global E1 not applied");
  a_override_ext: assert property (clk_en && !rx_term_override_pin
    |=> term_mode == '0) else $error("override did not force external");
  a_ext_no_res: assert property (ext_res_bad == '0)
    else $error("resistor code with external");
  a_single_ext: assert property (sing_term_bad == '0)
    else $error("single-ended not external");
  a_ready_pulse: assert property (pready && clk_en |=> !pready) else $error("pready too long");
  a_ready_due: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
endmodule // lrt_select_chk

bind lrt_select lrt_select_chk #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) chk
(
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .mode_strap_select(mode_strap_select),
  .line_standard_strap(line_standard_strap),
  .rx_term_override_pin(rx_term_override_pin),
  .e1_mode(e1_mode),
  .rx_neg_in_en(rx_neg_in_en),
  .term_mode(term_mode),
  .term_res_code(term_res_code)
);

//--- bench/testbench.sv
// Self-checking bench for the select block.
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int cmp_count = 0;
  wire [31:0] prdata;
  wire pready, pslverr, mode_strap_select, line_standard_strap, rx_term_override_pin;
  wire [16:0] e1_mode, rx_neg_in_en;
  wire [33:0] term_mode, term_res_code;
  // Clock of 100 ns period.
  always #50 pclk = ~pclk;
  lrt_select DUT
  (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mode_strap_select(mode_strap_select),
    .line_standard_strap(line_standard_strap),
    .rx_term_override_pin(rx_term_override_pin),
    .e1_mode(e1_mode),
    .rx_neg_in_en(rx_neg_in_en),
    .term_mode(term_mode),
    .term_res_code(term_res_code)
  );
  lrt_pin_ctl pins
  (
    .pclk(pclk),
    .mode_strap_select(mode_strap_select),
    .line_standard_strap(line_standard_strap),
    .rx_term_override_pin(rx_term_override_pin)
  );
  // Prints the verdict and ends the run.
  task conclude;
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Compares one value with its expectation.
  task chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, waiting for pready under a bound.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      $display("Error %0t: no pready", $time);
      conclude();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Lets one update edge pass and samples mid-cycle.
  task settle;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  // Reset values of outputs and of a config register.
  task t_reset;
    chk(rx_neg_in_en, {17{1'b1}});
    chk(term_mode, 0);
    apb(1'b0, 12'h080, 0);
    chk(rd, 32'h0000_0004);
  endtask
  // Global strap mode, then per-channel bits.
  task t_std;
    pins.set_pins(1'b1, 1'b0, 1'b1);
    settle;
    chk(e1_mode, {17{1'b1}});
    apb(1'b1, 12'h00C, 1);
    pins.set_pins(1'b1, 1'b1, 1'b1);
    settle;
    chk(e1_mode, 0);
    pins.set_pins(1'b0, 1'b0, 1'b1);
    settle;
    chk(e1_mode, 17'h0_0008);
    apb(1'b1, 12'h040, 1);
    apb(1'b1, 12'h00C, 0);
    settle;
    chk(e1_mode, 17'h1_0000);
  endtask
  // Every termination code with both fixed-resistor settings.
  task t_term;
    for (int c = 0; c < 16; c++)
    begin
      // The modelled line is transformer-coupled, so fully internal matching is legal.
      apb(1'b1, 12'h094, {27'h0, c[3], 1'b0, c[2:0]});
      settle;
      chk(term_mode[11:10], c[2] ? 2'h0 : (c[3] ? 2'h2 : 2'h1));
      chk(term_res_code[11:10], c[2] ? 2'h0 : c[1:0]);
    end
  endtask
  // Override pin, single-ended input and an unmapped read.
  task t_override;
    apb(1'b1, 12'h094, 32'h0000_0011);
    pins.set_pins(1'b0, 1'b0, 1'b0);
    settle;
    chk(term_mode, 0);
    chk(term_res_code, 0);
    pins.set_pins(1'b0, 1'b0, 1'b1);
    settle;
    chk(term_mode[11:10], 2'h2);
    apb(1'b1, 12'h094, 32'h0000_0019);
    settle;
    chk(rx_neg_in_en[5:4], 2'b01);
    chk(term_mode[11:10], 2'h0);
    apb(1'b0, 12'h044, 0);
    chk(er, 1);
    chk(rd, 0);
  endtask
  // Clock enable low freezes the outputs; raising it lets them follow the pins.
  task t_hold;
    @(posedge pclk);
    clk_en <= 1'b0;
    pins.set_pins(1'b1, 1'b0, 1'b0);
    settle;
    chk(e1_mode, 17'h1_0000);
    @(posedge pclk);
    clk_en <= 1'b1;
    settle;
    chk(e1_mode, {17{1'b1}});
    chk(term_mode, 0);
  endtask
  // Read-only status of channel 5 and the pin level register.
  task t_status;
    apb(1'b0, 12'h114, 0);
    chk(rd, 32'h0000_0003);
    apb(1'b0, 12'h180, 0);
    chk(rd, 32'h0000_0001);
  endtask
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset;
    t_std;
    t_term;
    t_override;
    t_hold;
    t_status;
    conclude();
  end
endmodule // testbench
